// File: src/slio_defs.svh
`ifndef SLIO_DEFS_SVH
`define SLIO_DEFS_SVH
// ==========================================
// register offsets
`define SLIO_OFS_CTRL 8'h00
`define SLIO_OFS_OUTCFG 8'h04
`define SLIO_OFS_STATUS 8'h08
`define SLIO_OFS_TAB 8'h20
`define SLIO_TAB_N 8
// ==========================================
// field positions
`define SLIO_CTRL_PC 0
`define SLIO_CTRL_POL 2:1
`define SLIO_CTRL_LACT 6:3
`define SLIO_CTRL_LPAR 15:8
`define SLIO_TAB_EN 31
`define SLIO_TAB_CODE 7:0
`define SLIO_TAB_MOD 9:8
`define SLIO_TAB_ACT 13:10
`define SLIO_TAB_PAR 23:16
// ==========================================
// reset values: logic input defaults to a momentary record press
`define SLIO_CTRL_RST 32'h0000_0200
`define SLIO_OUTCFG_RST 32'h0000_0000
// ==========================================
// key codes and modifiers
`define SLIO_K_F1 8'h01
`define SLIO_K_F12 8'h0C
`define SLIO_K_D0 8'h30
`define SLIO_K_D9 8'h39
`define SLIO_K_A 8'h41
`define SLIO_K_Z 8'h5A
`define SLIO_K_CONT 8'h80
`define SLIO_M_NONE 2'h0
`define SLIO_M_SHIFT 2'h1
`define SLIO_M_CTRL 2'h2
`define SLIO_M_ALT 2'h3
// ==========================================
// action types and button / transport codes
`define SLIO_A_MOM 4'h0
`define SLIO_A_TOG 4'h1
`define SLIO_A_MENU 4'h2
`define SLIO_A_CYC 4'h3
`define SLIO_A_SET 4'h4
`define SLIO_A_TCOPEN 4'h5
`define SLIO_A_TCJAM 4'h6
`define SLIO_A_TCEDIT 4'h7
`define SLIO_A_COMBO 4'h8
`define SLIO_B_PLAY 8'h01
`define SLIO_B_REC 8'h02
`define SLIO_S_UNDEF 3'h0
`define SLIO_S_REC 3'h3
`define SLIO_P_HIGH 2'h1
`define SLIO_P_LOW 2'h2
// ==========================================
// debounce timing
`define SLIO_DEB_US 1000
`define SLIO_CLK_MHZ 50
`endif

// File: src/slio_pkg.sv
`default_nettype none
package slio_pkg;
	// ==========================================
	// dispatcher states, gray along idle-match-emit
	typedef enum logic [1:0] {
		SLIO_IDLE = 2'b00,
		SLIO_MATCH = 2'b01,
		SLIO_EMIT = 2'b11
	} slio_fsm_type;
	// ==========================================
	// action handed to the recorder
	typedef struct packed {
		logic valid;
		logic [3:0] kind;
		logic [7:0] param;
	} slio_act_type;
	// ==========================================
	// whole module state
	typedef struct packed {
		slio_fsm_type fsm;
		logic [31:0] ctrl;
		logic [31:0] outcfg;
		logic [7:0][31:0] tab;
		logic [6:0] sy1;
		logic [6:0] sy2;
		logic [6:0] hist;
		logic [6:0] deb;
		logic [15:0] tcnt;
		logic tick;
		logic [6:0] pend;
		logic [7:0] code;
		logic [1:0] md;
		logic direct;
		logic [3:0] ckind;
		logic [7:0] cpar;
		logic [1:0] tog;
		slio_act_type act;
		logic key_ready;
		logic a_wr;
		logic a_sel;
		logic [7:0] a_addr;
		logic [31:0] hrdata;
		logic tally_o;
		logic tally_oe;
		logic [5:0] cont_o;
		logic [5:0] cont_oe;
	} slio_st_type;
endpackage
`default_nettype wire

// File: src/slio_top.sv
// The AHB-Lite slave port and the register offsets were decided locally.
`include "slio_defs.svh"
`default_nettype none
module slio_top
	import slio_pkg::*;
#(
	parameter int DEB_CYCLES = `SLIO_DEB_US * `SLIO_CLK_MHZ
) (
	input wire logic hclk, // system clock
	input wire logic hresetn, // async reset, active low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write strobe
	input wire logic [2:0] hsize, // word only
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic [31:0] hrdata, // read data
	output logic hreadyout, // always ready
	output logic hresp, // always okay
	input wire logic key_valid, // key event strobe
	input wire logic [7:0] key_code, // key code
	input wire logic [1:0] key_mod, // modifier
	output logic key_ready, // dispatcher free
	input wire logic [2:0] rec_state, // transport state
	output slio_act_type act, // action pulse
	input wire logic logic_in_n, // external logic input, active low
	output logic tally_o, // record tally level
	output logic tally_oe, // tally driven
	input wire logic [5:0] contact_i, // contact pins in
	output logic [5:0] contact_o, // contact pins out
	output logic [5:0] contact_oe // contact pins driven
);
	// ==========================================
	// helpers
	function automatic logic sc_legal(input logic [7:0] c, input logic [1:0] m);
		logic fk;
		logic an;
		fk = (c >= `SLIO_K_F1) && (c <= `SLIO_K_F12);
		an = ((c >= `SLIO_K_D0) && (c <= `SLIO_K_D9)) || ((c >= `SLIO_K_A) && (c <= `SLIO_K_Z));
		if (fk) begin
			return 1'b1;
		end
		if (an) begin
			return (m == `SLIO_M_CTRL) || (m == `SLIO_M_ALT);
		end
		return (c > `SLIO_K_CONT) && (c <= `SLIO_K_CONT + 8'h06) && (m == `SLIO_M_NONE);
	endfunction

	// scan downward so the lowest matching entry is the one kept
	function automatic logic [3:0] sc_find(input logic [7:0][31:0] t, input logic [7:0] c,
			input logic [1:0] m);
		logic [3:0] hit;
		hit = 4'h8;
		for (int i = `SLIO_TAB_N - 1; i >= 0; i--) begin
			if (t[i][`SLIO_TAB_EN] && t[i][`SLIO_TAB_CODE] == c && t[i][`SLIO_TAB_MOD] == m) begin
				hit = 4'(i);
			end
		end
		if (!sc_legal(c, m)) begin
			hit = 4'h8;
		end
		return hit;
	endfunction

	slio_st_type s_r;
	slio_st_type s_nxt;
	logic link_en;
	logic [6:0] in_mask;
	logic [6:0] fall;
	logic [3:0] hit;
	logic [31:0] rd;
	int pi;
	// table base as a sized constant so its upper bits can be selected
	localparam logic [7:0] TAB_BASE = `SLIO_OFS_TAB;

	assign hrdata = s_r.hrdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign key_ready = s_r.key_ready;
	assign act = s_r.act;
	assign tally_o = s_r.tally_o;
	assign tally_oe = s_r.tally_oe;
	assign contact_o = s_r.cont_o;
	assign contact_oe = s_r.cont_oe;

	// ==========================================
	// next state
	always_comb begin
		s_nxt = s_r;
		pi = 0;
		hit = 4'h8;
		rd = 32'h0000_0000;
		link_en = !s_r.ctrl[`SLIO_CTRL_PC];
		// contact inputs ignored on pins used as outputs or with the link off
		in_mask = {1'b1, s_r.outcfg[5:0] == 6'h00 ? {6{link_en}} : (~s_r.outcfg[5:0] & {6{link_en}})};
		// bus: data phase write, read data registered at address phase
		if (s_r.a_sel && s_r.a_wr) begin
			case (s_r.a_addr)
				`SLIO_OFS_CTRL: s_nxt.ctrl = hwdata;
				`SLIO_OFS_OUTCFG: s_nxt.outcfg = hwdata;
				default: begin
					if (s_r.a_addr[7:5] == TAB_BASE[7:5]) begin
						s_nxt.tab[s_r.a_addr[4:2]] = hwdata;
					end
				end
			endcase
		end
		s_nxt.a_sel = hsel && hready && htrans[1];
		s_nxt.a_wr = hwrite;
		s_nxt.a_addr = {haddr[7:2], 2'b00};
		case ({haddr[7:2], 2'b00})
			`SLIO_OFS_CTRL: rd = s_nxt.ctrl;
			`SLIO_OFS_OUTCFG: rd = s_nxt.outcfg;
			`SLIO_OFS_STATUS: rd = {20'h00000, rec_state, s_r.tog, s_r.deb};
			default: begin
				if (haddr[7:5] == TAB_BASE[7:5]) begin
					rd = s_nxt.tab[haddr[4:2]];
				end
			end
		endcase
		if (s_nxt.a_sel && !hwrite) begin
			s_nxt.hrdata = rd;
		end
		// two-flop synchroniser, tick-sampled debounce, falling edges
		s_nxt.sy1 = {logic_in_n, contact_i};
		s_nxt.sy2 = s_r.sy1;
		s_nxt.tick = s_r.tcnt == 16'(DEB_CYCLES - 1);
		s_nxt.tcnt = s_nxt.tick ? 16'h0000 : s_r.tcnt + 16'h0001;
		if (s_r.tick) begin
			s_nxt.hist = s_r.sy2;
			s_nxt.deb = (~(s_r.sy2 ^ s_r.hist) & s_r.sy2) | ((s_r.sy2 ^ s_r.hist) & s_r.deb);
		end
		fall = s_r.deb & ~s_nxt.deb & in_mask;
		// dispatcher
		s_nxt.act.valid = 1'b0;
		case (s_r.fsm)
			SLIO_IDLE: begin
				if (key_valid && s_r.key_ready) begin
					s_nxt.code = key_code;
					s_nxt.md = key_mod;
					s_nxt.direct = 1'b0;
					s_nxt.fsm = SLIO_MATCH;
				end else if (s_r.pend[6]) begin
					s_nxt.pend[6] = 1'b0;
					s_nxt.direct = 1'b1;
					s_nxt.ckind = s_r.ctrl[`SLIO_CTRL_LACT];
					s_nxt.cpar = s_r.ctrl[`SLIO_CTRL_LPAR];
					s_nxt.fsm = SLIO_MATCH;
				end else if (s_r.pend[5:0] != 6'h00) begin
					for (int i = 5; i >= 0; i--) begin
						if (s_r.pend[i]) begin
							pi = i;
						end
					end
					s_nxt.pend[pi] = 1'b0;
					s_nxt.code = `SLIO_K_CONT + 8'(pi + 1);
					s_nxt.md = `SLIO_M_NONE;
					s_nxt.direct = 1'b0;
					s_nxt.fsm = SLIO_MATCH;
				end
			end
			SLIO_MATCH: begin
				hit = sc_find(s_r.tab, s_r.code, s_r.md);
				s_nxt.fsm = SLIO_EMIT;
				if (!s_r.direct) begin
					if (hit[3]) begin
						s_nxt.fsm = SLIO_IDLE;
					end else begin
						s_nxt.ckind = s_r.tab[hit[2:0]][`SLIO_TAB_ACT];
						s_nxt.cpar = s_r.tab[hit[2:0]][`SLIO_TAB_PAR];
					end
				end
			end
			SLIO_EMIT: begin
				s_nxt.fsm = SLIO_IDLE;
				s_nxt.act.kind = s_r.ckind;
				s_nxt.act.param = s_r.cpar;
				// momentary, menu, cycle, set, time code and combo pass straight on
				s_nxt.act.valid = s_r.ckind <= `SLIO_A_COMBO;
				if (s_r.ckind == `SLIO_A_TOG) begin
					if (s_r.cpar == `SLIO_B_PLAY || s_r.cpar == `SLIO_B_REC) begin
						s_nxt.tog[s_r.cpar[1]] = !s_r.tog[s_r.cpar[1]];
						s_nxt.act.param = {!s_r.tog[s_r.cpar[1]], s_r.cpar[6:0]};
					end else begin
						s_nxt.act.valid = 1'b0;
					end
				end
			end
			default: s_nxt.fsm = SLIO_IDLE;
		endcase
		// set wins over the clear taken above
		s_nxt.pend = s_nxt.pend | fall;
		s_nxt.key_ready = s_nxt.fsm == SLIO_IDLE;
		// tally and contact outputs
		s_nxt.tally_o = (rec_state == `SLIO_S_REC) ^ (s_r.ctrl[`SLIO_CTRL_POL] == `SLIO_P_LOW);
		s_nxt.tally_oe = s_r.ctrl[`SLIO_CTRL_POL] == `SLIO_P_HIGH ||
			s_r.ctrl[`SLIO_CTRL_POL] == `SLIO_P_LOW;
		for (int i = 0; i < 6; i++) begin
			s_nxt.cont_o[i] = !(s_r.outcfg[6 + 3 * i +: 3] != `SLIO_S_UNDEF &&
				s_r.outcfg[6 + 3 * i +: 3] == rec_state);
		end
		s_nxt.cont_oe = s_r.outcfg[5:0] & {6{link_en}};
	end

	// ==========================================
	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= '0;
			s_r.ctrl <= `SLIO_CTRL_RST;
			s_r.outcfg <= `SLIO_OUTCFG_RST;
			s_r.sy1 <= 7'h7F;
			s_r.sy2 <= 7'h7F;
			s_r.hist <= 7'h7F;
			s_r.deb <= 7'h7F;
			s_r.cont_o <= 6'h3F;
			s_r.key_ready <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================
	// checks
	a_ready_idle: assert property (@(posedge hclk) disable iff (!hresetn)
		key_ready == (s_r.fsm == SLIO_IDLE)) else $error("key_ready disagrees with state");
	a_act_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
		act.valid |=> !act.valid) else $error("action pulse longer than one cycle");
	a_key_path: assert property (@(posedge hclk) disable iff (!hresetn)
		key_valid && key_ready |=> s_r.fsm == SLIO_MATCH ##1 s_r.fsm != SLIO_MATCH)
		else $error("key event not matched");
	a_tog_only: assert property (@(posedge hclk) disable iff (!hresetn)
		act.valid && act.kind == `SLIO_A_TOG |-> act.param[6:0] == 7'h01 || act.param[6:0] == 7'h02)
		else $error("toggle on unsupported function");
	a_tally_pol: assert property (@(posedge hclk) disable iff (!hresetn)
		$stable(s_r.ctrl) && s_r.ctrl[2:1] == `SLIO_P_HIGH ##1 $stable(s_r.ctrl)
		|-> tally_oe && tally_o == ($past(rec_state) == `SLIO_S_REC))
		else $error("tally does not follow record");
	a_link_off: assert property (@(posedge hclk) disable iff (!hresetn)
		s_r.ctrl[0] && $past(s_r.ctrl[0]) |-> contact_oe == 6'h00 && s_r.pend[5:0] == 6'h00 ||
		$past(s_r.pend[5:0]) != 6'h00) else $error("remote link active in computer mode");
	a_out_wins: assert property (@(posedge hclk) disable iff (!hresetn)
		1'b1 ##1 $stable(s_r.outcfg) |->
		(s_r.pend[5:0] & ~$past(s_r.pend[5:0]) & s_r.outcfg[5:0]) == 6'h00)
		else $error("input edge taken on an output pin");
	a_cont_low: assert property (@(posedge hclk) disable iff (!hresetn)
		$stable(rec_state) && $stable(s_r.outcfg) && s_r.outcfg[8:6] == rec_state &&
		rec_state != 3'h0 |=> !contact_o[0]) else $error("contact output not low when active");
	a_deb_tick: assert property (@(posedge hclk) disable iff (!hresetn)
		!s_r.tick |=> $stable(s_r.deb)) else $error("debounced level moved off tick");
endmodule
`default_nettype wire

// File: verification/slio_remote_side.sv
`default_nettype none
// ======
// far side: mixer logic line and six pulled-up contact switches
module slio_remote_side (
	input wire logic [5:0] sw_closed, // switch closed per pin
	input wire logic mixer_rec, // mixer rolls record
	input wire logic [5:0] contact_o, // device drive level
	input wire logic [5:0] contact_oe, // device drives pin
	output logic [5:0] contact_i, // resolved pin level
	output logic logic_in_n // mixer logic line
);
	timeunit 1ns;
	timeprecision 1ps;
	// closed switch grounds the pin, else driver or pull-up
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			contact_i[i] = sw_closed[i] ? 1'b0 : (contact_oe[i] ? contact_o[i] : 1'b1);
		end
		logic_in_n = !mixer_rec; // mixer pulls low to roll
	end
endmodule
`default_nettype wire

// File: verification/tb_shortcut_logic_io_dispatch.sv
`include "slio_defs.svh"
`default_nettype none
module tb_shortcut_logic_io_dispatch import slio_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk, hresetn, hsel, hwrite, key_valid, mixer_rec, hreadyout, hresp;
	logic key_ready, tally_o, tally_oe, logic_in_n;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0] htrans, key_mod;
	logic [7:0] key_code;
	logic [2:0] rec_state;
	logic [5:0] sw_closed, contact_i, contact_o, contact_oe;
	slio_act_type act, g;
	int errors, n_compared, cyc;
	// ======
	// design and far side
	slio_top #(.DEB_CYCLES(4)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.key_valid(key_valid), .key_code(key_code), .key_mod(key_mod), .key_ready(key_ready),
		.rec_state(rec_state), .act(act), .logic_in_n(logic_in_n), .tally_o(tally_o),
		.tally_oe(tally_oe), .contact_i(contact_i), .contact_o(contact_o),
		.contact_oe(contact_oe));
	slio_remote_side far_u (.sw_closed(sw_closed), .mixer_rec(mixer_rec),
		.contact_o(contact_o), .contact_oe(contact_oe), .contact_i(contact_i),
		.logic_in_n(logic_in_n));
	// 50 MHz clock
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	// ======
	// report and verdict
	task automatic stop_test;
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// hang guard
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			stop_test;
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
			errors++;
		end
	endtask
	// one single ahb transfer, waits on hready in both phases
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask
	function automatic logic [31:0] ent(logic [7:0] c, logic [1:0] m, logic [3:0] k,
		logic [7:0] p);
		return {1'b1, 7'h00, p, 2'h0, k, m, c};
	endfunction
	function automatic logic [31:0] ea(logic [3:0] k, logic [7:0] p);
		return {19'h0, 1'b1, k, p};
	endfunction
	// first action pulse seen within n cycles
	task automatic watch(input int n);
		g = '0;
		repeat (n) begin
			@(posedge hclk);
			if (act.valid === 1'b1 && g.valid !== 1'b1) g = act;
		end
	endtask
	task automatic press(input logic [7:0] c, input logic [1:0] m);
		@(posedge hclk);
		while (key_ready !== 1'b1) @(posedge hclk);
		key_valid <= 1'b1;
		key_code <= c;
		key_mod <= m;
		@(posedge hclk);
		key_valid <= 1'b0;
		watch(8);
	endtask
	task automatic sw(input logic [5:0] s);
		@(posedge hclk);
		sw_closed <= s;
		watch(60);
	endtask
	task automatic settle(input logic [2:0] s);
		@(posedge hclk);
		rec_state <= s;
		repeat (3) @(posedge hclk);
	endtask
	// ======
	// scenarios
	task automatic t_regs;
		check({tally_oe, contact_oe}, 32'h0);
		check({hreadyout, hresp}, 32'h2);
		bus(1'b0, `SLIO_OFS_CTRL, 32'h0);
		check(q, 32'h0000_0200);
		bus(1'b0, `SLIO_OFS_OUTCFG, 32'h0);
		check(q, 32'h0);
		bus(1'b0, 32'h10, 32'h0);
		check(q, 32'h0);
	endtask
	task automatic t_keys;
		bus(1'b1, `SLIO_OFS_TAB, ent(`SLIO_K_F1, `SLIO_M_NONE, `SLIO_A_MOM, 8'h05));
		bus(1'b1, `SLIO_OFS_TAB + 8'h04, ent(`SLIO_K_F1, `SLIO_M_NONE, `SLIO_A_SET, 8'h07));
		bus(1'b1, `SLIO_OFS_TAB + 8'h08, ent(`SLIO_K_F12, `SLIO_M_SHIFT, `SLIO_A_CYC, 8'h09));
		bus(1'b1, `SLIO_OFS_TAB + 8'h0C, ent(`SLIO_K_D0, `SLIO_M_NONE, `SLIO_A_TCOPEN, 8'h01));
		bus(1'b1, `SLIO_OFS_TAB + 8'h10, ent(`SLIO_K_A, `SLIO_M_ALT, `SLIO_A_COMBO, 8'h11));
		bus(1'b1, `SLIO_OFS_TAB + 8'h18, ent(`SLIO_K_Z, `SLIO_M_CTRL, `SLIO_A_TCJAM, 8'h03));
		press(`SLIO_K_F1, `SLIO_M_NONE);
		check(g, ea(`SLIO_A_MOM, 8'h05));
		press(`SLIO_K_F12, `SLIO_M_SHIFT);
		check(g, ea(`SLIO_A_CYC, 8'h09));
		press(`SLIO_K_D0, `SLIO_M_NONE);
		check(g, 32'h0);
		press(`SLIO_K_A, `SLIO_M_ALT);
		check(g, ea(`SLIO_A_COMBO, 8'h11));
		press(`SLIO_K_Z, `SLIO_M_CTRL);
		check(g, ea(`SLIO_A_TCJAM, 8'h03));
	endtask
	// toggle flips record state; other targets are dropped
	task automatic t_tog;
		bus(1'b1, `SLIO_OFS_TAB + 8'h14, ent(8'h02, `SLIO_M_NONE, `SLIO_A_TOG, `SLIO_B_REC));
		bus(1'b1, `SLIO_OFS_TAB + 8'h0C, ent(8'h03, `SLIO_M_NONE, `SLIO_A_TOG, 8'h05));
		press(8'h02, `SLIO_M_NONE);
		check(g, ea(`SLIO_A_TOG, 8'h82));
		press(8'h02, `SLIO_M_NONE);
		check(g, ea(`SLIO_A_TOG, 8'h02));
		press(8'h03, `SLIO_M_NONE);
		check(g, 32'h0);
	endtask
	task automatic t_logic;
		@(posedge hclk);
		mixer_rec <= 1'b1;
		watch(60);
		check(g, ea(`SLIO_A_MOM, `SLIO_B_REC));
		@(posedge hclk);
		mixer_rec <= 1'b0;
		watch(40);
		check(g, 32'h0);
	endtask
	// tally level against record state and polarity
	task automatic t_tally;
		bus(1'b1, `SLIO_OFS_CTRL, 32'h0000_0202);
		settle(`SLIO_S_REC);
		check({tally_oe, tally_o}, 32'h3);
		bus(1'b1, `SLIO_OFS_CTRL, 32'h0000_0204);
		settle(`SLIO_S_REC);
		check({tally_oe, tally_o}, 32'h2);
		settle(3'h1);
		check({tally_oe, tally_o}, 32'h3);
		bus(1'b1, `SLIO_OFS_CTRL, 32'h0000_0200);
		settle(3'h1);
		check(tally_oe, 32'h0);
	endtask
	task automatic t_contact;
		bus(1'b1, `SLIO_OFS_TAB + 8'h1C, ent(8'h82, `SLIO_M_NONE, `SLIO_A_MOM, 8'h0A));
		bus(1'b1, `SLIO_OFS_OUTCFG, 32'h0000_00C1);
		settle(`SLIO_S_REC);
		check({contact_oe, contact_o}, 32'h07E);
		settle(3'h4);
		check(contact_o, 32'h3F);
		sw(6'h02);
		check(g, ea(`SLIO_A_MOM, 8'h0A));
		sw(6'h00);
		check(g, 32'h0);
		bus(1'b1, `SLIO_OFS_OUTCFG, 32'h0000_00C3);
		sw(6'h02);
		check(g, 32'h0);
		sw(6'h00);
		bus(1'b1, `SLIO_OFS_OUTCFG, 32'h0000_00C1);
		bus(1'b1, `SLIO_OFS_CTRL, 32'h0000_0201);
		sw(6'h02);
		check(g, 32'h0);
		check(contact_oe, 32'h0);
		sw(6'h00);
	endtask
	// ======
	// main sequence
	initial begin
		{hresetn, hsel, hwrite, key_valid, mixer_rec} = 5'h00;
		{haddr, hwdata} = 64'h0;
		{htrans, key_mod, key_code, rec_state, sw_closed} = 21'h0;
		{errors, n_compared, cyc} = {32'h0, 32'h0, 32'h0};
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs;
		t_keys;
		t_tog;
		t_logic;
		t_tally;
		t_contact;
		stop_test;
	end
endmodule
`default_nettype wire
